// ### bench/cksel_chk_sva.sv
// Checker for the clock steering block, sees only top-level ports.
// Assumes straps stay put for a few cycles and reads never meet writes.
`timescale 1ns/1ps

module cksel_chk
  import cksel_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Sources and straps
  input wire logic frequency_locked_loop,
  input wire logic osc_clk,
  input wire logic general_pin_two,
  input wire logic clock_override_strap,
  input wire logic strap_pin,
  input wire logic [4:0] crystal_in_trim_value,
  // Outputs
  input wire logic clk_out_a,
  input wire logic clk_out_b,
  input wire logic clk_out_c,
  input wire logic [3:0] crystal_in_cap_adjust,
  input wire logic [3:0] crystal_out_cap_adjust
);
  // Cycles since reset, strap-low ages, shadow of the A select
  logic [3:0] up_q, flo_q, cfo_q;
  logic [1:0] a_q;
  logic k_q;
  logic adj_wr;

  assign adj_wr = reg_wr && reg_addr == 8'h77;

  // Ages saturate so the guards never wrap back to zero
  always_ff @(posedge clk)
    if (!nrst)
    begin
      up_q <= 4'h0;
      a_q <= 2'h0;
      k_q <= 1'b0;
    end
    else
    begin
      up_q <= (up_q == 4'hf) ? up_q : up_q + 4'h1;
      a_q <= (reg_wr && reg_addr == 8'h7c) ? reg_wdata[6:5] : a_q;
      // Key shadow: exact value opens, any other write closes
      k_q <= (reg_wr && reg_addr == CKSEL_OFF_KEY) ? (reg_wdata == CKSEL_KEY_VALUE) : k_q;
    end

  // Strap ages run in reset too, straps are pins
  always_ff @(posedge clk)
  begin
    flo_q <= clock_override_strap ? 4'h0 : ((flo_q == 4'hf) ? flo_q : flo_q + 4'h1);
    cfo_q <= (clock_override_strap || strap_pin) ? 4'h0 :
             ((cfo_q == 4'hf) ? cfo_q : cfo_q + 4'h1);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  src_read_a: assert property (reg_rd && reg_addr == 8'h7c |=> reg_rdata[6:5] == $past(a_q)
    && reg_rdata[15:7] == 9'h000 && reg_rdata[2:1] == 2'h0) else $error("source readback");
  unmap_rd_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  trim_read_a: assert property (reg_rd && reg_addr == 8'h73 |=> reg_rdata ==
    ($past(k_q) ? {11'h000, $past(crystal_in_trim_value)} : 16'h0000))
    else $error("trim readback");
  adj_write_a: assert property (adj_wr |=>
    {crystal_out_cap_adjust, crystal_in_cap_adjust} == $past(reg_wdata[7:0]))
    else $error("adjust write lost");
  adj_hold_a: assert property (!adj_wr |=> $stable({crystal_out_cap_adjust,
    crystal_in_cap_adjust})) else $error("adjust changed unasked");
  a_osc_a: assert property (up_q > 4'h5 && $past(a_q) == 2'h2
    |-> clk_out_a == $past(osc_clk, 3)) else $error("output a not oscillator");
  a_pin_a: assert property (up_q > 4'h5 && $past(a_q) == 2'h1
    |-> clk_out_a == $past(general_pin_two, 3)) else $error("output a not pin two");
  a_rsv_a: assert property (up_q > 4'h5 && $past(a_q) == 2'h3 |-> !clk_out_a)
    else $error("reserved code not quiet");
  b_forced_a: assert property (flo_q > 4'h8
    |-> clk_out_b == $past(frequency_locked_loop, 3)) else $error("output b not loop");
  c_forced_a: assert property (cfo_q > 4'h8
    |-> clk_out_c == $past(frequency_locked_loop, 3)) else $error("output c not loop");
endmodule : cksel_chk

// ### bench/cksel_src_model.sv
// Source model: loops, oscillator and pins as square waves of fixed half periods.
// Assumes the bench clock; edges land on the falling edge, away from sampling.
`timescale 1ns/1ps

module cksel_src_model
(
  // Bench clock
  input wire logic clk,
  // Free-running sources
  output logic phase_loop_b,
  output logic phase_loop_c,
  output logic frequency_locked_loop,
  output logic osc_clk,
  output logic general_pin_two,
  output logic general_pin_three
);
  // Cycle count that all waves derive from
  int n = 0;

  always @(negedge clk)
    n <= n + 1;

  // Half periods 3, 5, 2, 7, 4 and 6 cycles
  assign phase_loop_b = ((n / 3) % 2) == 1;
  assign phase_loop_c = ((n / 5) % 2) == 1;
  assign frequency_locked_loop = ((n / 2) % 2) == 1;
  assign osc_clk = ((n / 7) % 2) == 1;
  assign general_pin_two = ((n / 4) % 2) == 1;
  assign general_pin_three = ((n / 6) % 2) == 1;
endmodule : cksel_src_model

// ### bench/testbench.sv
// Top bench: register scenarios, output rates and strap forcing.
// Assumes the source model's half periods given in the rate calls.
`timescale 1ns/1ps

module testbench;
  import cksel_pkg::*;
  logic clk, nrst, reg_wr, reg_rd, clock_override_strap, strap_pin;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [4:0] crystal_in_trim_value, crystal_out_trim_value;
  logic [3:0] crystal_in_cap_adjust, crystal_out_cap_adjust;
  logic phase_loop_b, phase_loop_c, frequency_locked_loop, osc_clk;
  logic general_pin_two, general_pin_three, clk_out_a, clk_out_b, clk_out_c;
  int failures = 0;
  int samples_checked = 0;

  cksel_top cksel_top_i (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .phase_loop_b, .phase_loop_c, .frequency_locked_loop, .osc_clk, .general_pin_two,
    .general_pin_three, .clock_override_strap, .strap_pin, .crystal_in_trim_value,
    .crystal_out_trim_value, .clk_out_a, .clk_out_b, .clk_out_c, .crystal_in_cap_adjust,
    .crystal_out_cap_adjust);
  cksel_src_model cksel_src_model_i (.clk, .phase_loop_b, .phase_loop_c,
    .frequency_locked_loop, .osc_clk, .general_pin_two, .general_pin_three);

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Compare one value
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
      failures++;
    if (got !== exp)
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
  endtask : cmp

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read, data judged in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata, exp);
    @(posedge clk);
  endtask : rd

  // Rising edges of one output over 240 cycles, one edge of slack for phase
  task automatic rate(input logic [15:0] v, input int o, input int hp, input int dv);
    int n, ex;
    logic p;
    logic [2:0] q;
    n = 0;
    ex = (hp == 0) ? 0 : 240 / (2 * hp * dv);
    wr(8'h7c, v);
    repeat (8) @(posedge clk);
    p = 1'b0;
    repeat (240)
    begin
      @(posedge clk);
      #1;
      q = {clk_out_c, clk_out_b, clk_out_a};
      if (q[o] === 1'b1 && !p)
        n++;
      p = q[o] === 1'b1;
    end
    if (n >= ex - 1 && n <= ex + 1)
      n = ex;
    cmp(16'(n), 16'(ex));
    // Back on the edge so the next request starts there
    @(posedge clk);
  endtask : rate

  // Reset values with override high
  task automatic t_reset;
    rd(8'h7c, 16'h0000);
    rd(8'h7d, 16'h0040);
    rd(8'h77, 16'h0000);
    rd(8'h00, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  // Extreme signed adjust codes, unused bits dropped
  task automatic t_adjust;
    wr(8'h77, 16'hff87);
    #1;
    cmp({8'h00, crystal_out_cap_adjust, crystal_in_cap_adjust}, 16'h0087);
    @(posedge clk);
    rd(8'h77, 16'h0087);
    $display("test adjust done");
  endtask : t_adjust

  // Key gate and read-only trim codes
  task automatic t_trim;
    rd(8'h73, 16'h0000);
    wr(CKSEL_OFF_KEY, CKSEL_KEY_VALUE);
    rd(8'h73, 16'h001f);
    rd(8'h74, 16'h000a);
    wr(8'h73, 16'h0000);
    rd(8'h73, 16'h001f);
    wr(CKSEL_OFF_KEY, 16'h0000);
    rd(8'h74, 16'h0000);
    $display("test trim done");
  endtask : t_trim

  // Every source code of every output
  task automatic t_rates;
    rate(16'h0000, 0, 3, 2);
    rate(16'h0020, 0, 4, 1);
    rate(16'h0040, 0, 7, 1);
    rate(16'h0060, 0, 0, 1);
    rate(16'h0000, 1, 5, 4);
    rate(16'h0008, 1, 6, 1);
    rate(16'h0010, 1, 2, 1);
    rate(16'h0018, 1, 0, 1);
    rate(16'h0000, 2, 7, 1);
    rate(16'h0001, 2, 2, 1);
    wr(8'h7d, 16'h0080);
    rd(8'h7d, 16'h0080);
    rate(16'h0000, 0, 3, 4);
    wr(8'h7d, 16'h0000);
    rd(8'h7d, 16'h0000);
    rate(16'h0000, 1, 5, 2);
    $display("test rates done");
  endtask : t_rates

  // Strap combinations, forced fields read back forced values
  task automatic t_straps;
    clock_override_strap <= 1'b0;
    repeat (9) @(posedge clk);
    rd(8'h7c, 16'h0011);
    wr(8'h7c, 16'h0040);
    rd(8'h7c, 16'h0051);
    strap_pin <= 1'b1;
    repeat (9) @(posedge clk);
    rd(8'h7c, 16'h0050);
    wr(8'h7c, 16'h0041);
    rd(8'h7c, 16'h0051);
    clock_override_strap <= 1'b1;
    repeat (9) @(posedge clk);
    rd(8'h7c, 16'h0040);
    wr(8'h7c, 16'h0049);
    rd(8'h7c, 16'h0049);
    $display("test straps done");
  endtask : t_straps

  // Counts, verdict and end of run
  task automatic test_done;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // Main sequence
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    clock_override_strap = 1'b1;
    strap_pin = 1'b0;
    crystal_in_trim_value = 5'h1f;
    crystal_out_trim_value = 5'h0a;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset;
    t_adjust;
    t_trim;
    t_rates;
    t_straps;
    test_done;
  end

  // Watchdog, far beyond the expected few thousand cycles
  initial
  begin
    #(25 * 40000);
    failures++;
    test_done;
  end
endmodule : testbench

bind cksel_top cksel_chk cksel_chk_i (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .frequency_locked_loop, .osc_clk, .general_pin_two, .clock_override_strap,
  .strap_pin, .crystal_in_trim_value, .clk_out_a, .clk_out_b, .clk_out_c,
  .crystal_in_cap_adjust, .crystal_out_cap_adjust);

// ### src/cksel_pkg.sv
// Package for the clock output steering and crystal trim block.
// Assumes a 40 MHz system clock and a plain address/strobe register port.
package cksel_pkg;

  // Register port widths
  localparam int CKSEL_AW = 8;
  localparam int CKSEL_DW = 16;

  // Register word offsets
  localparam logic [7:0] CKSEL_OFF_IN_CAP_RB = 8'h73;
  localparam logic [7:0] CKSEL_OFF_OUT_CAP_RB = 8'h74;
  localparam logic [7:0] CKSEL_OFF_CAP_ADJ = 8'h77;
  localparam logic [7:0] CKSEL_OFF_KEY = 8'h7a;
  localparam logic [7:0] CKSEL_OFF_SRC_SEL = 8'h7c;
  localparam logic [7:0] CKSEL_OFF_DIV_CTRL = 8'h7d;

  // Security key value; arbitrary
  localparam logic [15:0] CKSEL_KEY_VALUE = 16'h5a3c;

  // Field positions, source select register
  localparam int CKSEL_A_SRC_LO = 5;
  localparam int CKSEL_B_SRC_LO = 3;
  localparam int CKSEL_C_SRC_BIT = 0;
  // Field positions, divider register
  localparam int CKSEL_B_DIV_BIT = 7;
  localparam int CKSEL_C_DIV_BIT = 6;
  // Field positions, capacitance adjust register
  localparam int CKSEL_OUT_ADJ_LO = 4;
  localparam int CKSEL_IN_ADJ_LO = 0;
  localparam int CKSEL_TRIM_W = 5;
  localparam int CKSEL_ADJ_W = 4;

  // Output A source codes
  localparam logic [1:0] CKSEL_A_PHASE_B = 2'h0;
  localparam logic [1:0] CKSEL_A_PIN_TWO = 2'h1;
  localparam logic [1:0] CKSEL_A_OSC = 2'h2;
  // Output B source codes
  localparam logic [1:0] CKSEL_B_PHASE_C = 2'h0;
  localparam logic [1:0] CKSEL_B_PIN_THREE = 2'h1;
  localparam logic [1:0] CKSEL_B_FLL = 2'h2;
  // Output C source codes
  localparam logic CKSEL_C_OSC = 1'h0;
  localparam logic CKSEL_C_FLL = 1'h1;

  // Reset values
  localparam logic [1:0] CKSEL_A_SRC_RST = 2'h0;
  localparam logic CKSEL_B_DIV_RST = 1'h0;
  localparam logic CKSEL_C_DIV_RST = 1'h1;
  localparam logic [3:0] CKSEL_ADJ_RST = 4'h0;
  // Cycles after reset during which strap defaults are loaded
  localparam logic [1:0] CKSEL_INIT_CYCLES = 2'h3;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } cksel_bus_req_t;

  // Raw clock sources and straps
  typedef struct packed {
    logic phase_loop_b;
    logic phase_loop_c;
    logic frequency_locked_loop;
    logic osc;
    logic general_pin_two;
    logic general_pin_three;
    logic clock_override_strap;
    logic strap_pin;
  } cksel_src_t;

endpackage : cksel_pkg

// ### src/cksel_top.sv
// Clock output steering, loop post dividers and crystal trim registers.
// Assumes sources and straps arrive from pins and are synchronised here;
// the register port master keeps one-cycle strobes, never both at once.
`timescale 1ns/1ps

module cksel_top
  import cksel_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Clock sources and straps, asynchronous pins
  input wire logic phase_loop_b,
  input wire logic phase_loop_c,
  input wire logic frequency_locked_loop,
  input wire logic osc_clk,
  input wire logic general_pin_two,
  input wire logic general_pin_three,
  input wire logic clock_override_strap,
  input wire logic strap_pin,
  // Factory trim codes, static after power-up
  input wire logic [4:0] crystal_in_trim_value,
  input wire logic [4:0] crystal_out_trim_value,
  // Clock outputs
  output logic clk_out_a,
  output logic clk_out_b,
  output logic clk_out_c,
  // Capacitance adjust to the oscillator
  output logic [3:0] crystal_in_cap_adjust,
  output logic [3:0] crystal_out_cap_adjust
);

  // Whole state of the block
  typedef struct packed {
    cksel_src_t sync1;         // First synchroniser stage
    cksel_src_t sync2;         // Second synchroniser stage
    logic b_loop_prev;         // Edge detect history
    logic c_loop_prev;         // Edge detect history
    logic [1:0] b_loop_cnt;    // B loop post divider count
    logic [1:0] c_loop_cnt;    // C loop post divider count
    logic ovr_prev;            // Strap change detect
    logic pin_prev;            // Strap change detect
    logic [1:0] init_cnt;      // Strap default load window
    logic [1:0] a_src;         // Output A source
    logic [1:0] b_src;         // Output B stored source
    logic c_src;               // Output C stored source
    logic b_div;               // B loop divider select
    logic c_div;               // C loop divider select
    logic [3:0] out_adj;       // Crystal out adjust
    logic [3:0] in_adj;        // Crystal in adjust
    logic [4:0] in_trim_s;     // Trim synchroniser first stage, in side
    logic [4:0] out_trim_s;    // Trim synchroniser first stage, out side
    logic [4:0] in_trim;       // Captured trim, in side
    logic [4:0] out_trim;      // Captured trim, out side
    logic unlocked;            // Security key accepted
    logic [15:0] rdata;        // Read data for one cycle
    logic out_a;               // Output A flop
    logic out_b;               // Output B flop
    logic out_c;               // Output C flop
  } cksel_state_t;

  cksel_state_t state_q;
  cksel_state_t state_d;
  cksel_bus_req_t req;         // Bundled register request
  cksel_src_t src_raw;         // Bundled raw pins
  logic ovr;                   // Synchronised override strap
  logic pin5;                  // Synchronised strap pin
  logic [1:0] b_src_eff;       // Effective output B source
  logic c_src_eff;             // Effective output C source
  logic b_loop_div;            // Divided B loop clock
  logic c_loop_div;            // Divided C loop clock

  // Pick a divided phase from a two-bit edge counter
  function automatic logic post_div(input logic [1:0] cnt, input logic by_four);
    post_div = by_four ? cnt[1] : cnt[0];
  endfunction : post_div

  // Rising edge of a synchronised level
  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction : rise

  // Bundle ports into carriers
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign src_raw = '{
    phase_loop_b: phase_loop_b,
    phase_loop_c: phase_loop_c,
    frequency_locked_loop: frequency_locked_loop,
    osc: osc_clk,
    general_pin_two: general_pin_two,
    general_pin_three: general_pin_three,
    clock_override_strap: clock_override_strap,
    strap_pin: strap_pin
  };

  // Straps read only from the second stage
  assign ovr = state_q.sync2.clock_override_strap;
  assign pin5 = state_q.sync2.strap_pin;

  // Effective selects; forced values win over the stored field
  always_comb
  begin
    if (!ovr)
    begin
      b_src_eff = CKSEL_B_FLL;
    end
    else
    begin
      b_src_eff = state_q.b_src;
    end
    if (!ovr && !pin5)
    begin
      c_src_eff = CKSEL_C_FLL;
    end
    else
    begin
      c_src_eff = state_q.c_src;
    end
  end

  // Post divider taps
  assign b_loop_div = post_div(state_q.b_loop_cnt, state_q.b_div);
  assign c_loop_div = post_div(state_q.c_loop_cnt, state_q.c_div);

  // Next-state logic for the whole block
  always_comb
  begin
    logic strap_change;
    logic wr_src;
    logic wr_div;
    logic wr_adj;
    strap_change = 1'b0;
    wr_src = 1'b0;
    wr_div = 1'b0;
    wr_adj = 1'b0;
    state_d = state_q;

    // Two-stage synchroniser on every pin
    state_d.sync1 = src_raw;
    state_d.sync2 = state_q.sync1;

    // Post dividers count source edges; the 40 MHz clock limits source rate
    state_d.b_loop_prev = state_q.sync2.phase_loop_b;
    state_d.c_loop_prev = state_q.sync2.phase_loop_c;
    if (rise(state_q.sync2.phase_loop_b, state_q.b_loop_prev))
    begin
      state_d.b_loop_cnt = state_q.b_loop_cnt + 2'h1;
    end
    if (rise(state_q.sync2.phase_loop_c, state_q.c_loop_prev))
    begin
      state_d.c_loop_cnt = state_q.c_loop_cnt + 2'h1;
    end

    // Trim codes are captured continuously; software cannot alter them
    state_d.in_trim_s = crystal_in_trim_value;
    state_d.out_trim_s = crystal_out_trim_value;
    state_d.in_trim = state_q.in_trim_s;
    state_d.out_trim = state_q.out_trim_s;

    // Decode writes
    wr_src = req.wr && (req.addr == CKSEL_OFF_SRC_SEL);
    wr_div = req.wr && (req.addr == CKSEL_OFF_DIV_CTRL);
    wr_adj = req.wr && (req.addr == CKSEL_OFF_CAP_ADJ);

    // Register writes
    if (wr_src)
    begin
      state_d.a_src = req.wdata[CKSEL_A_SRC_LO +: 2];
      if (ovr)
      begin
        state_d.b_src = req.wdata[CKSEL_B_SRC_LO +: 2];
      end
      if (ovr || pin5)
      begin
        state_d.c_src = req.wdata[CKSEL_C_SRC_BIT];
      end
    end
    if (wr_div)
    begin
      state_d.b_div = req.wdata[CKSEL_B_DIV_BIT];
      state_d.c_div = req.wdata[CKSEL_C_DIV_BIT];
    end
    if (wr_adj)
    begin
      state_d.out_adj = req.wdata[CKSEL_OUT_ADJ_LO +: CKSEL_ADJ_W];
      state_d.in_adj = req.wdata[CKSEL_IN_ADJ_LO +: CKSEL_ADJ_W];
    end

    // Key register: exact match unlocks, anything else locks again
    if (req.wr && (req.addr == CKSEL_OFF_KEY))
    begin
      state_d.unlocked = (req.wdata == CKSEL_KEY_VALUE);
    end

    // Strap defaults reload after reset and whenever a strap moves
    state_d.ovr_prev = ovr;
    state_d.pin_prev = pin5;
    strap_change = (ovr != state_q.ovr_prev) || (pin5 != state_q.pin_prev);
    if (state_q.init_cnt != 2'h0)
    begin
      state_d.init_cnt = state_q.init_cnt - 2'h1;
    end
    // Defaults win over a write in the same cycle, so straps always settle
    if ((state_q.init_cnt != 2'h0) || strap_change)
    begin
      state_d.b_src = ovr ? CKSEL_B_PHASE_C : CKSEL_B_FLL;
      state_d.c_src = (ovr || pin5) ? CKSEL_C_OSC : CKSEL_C_FLL;
    end

    // Read data stands one cycle only
    state_d.rdata = 16'h0000;
    if (req.rd)
    begin
      case (req.addr)
        CKSEL_OFF_IN_CAP_RB:
        begin
          // Hidden unless the key was given
          if (state_q.unlocked)
          begin
            state_d.rdata[CKSEL_TRIM_W-1:0] = state_q.in_trim;
          end
        end
        CKSEL_OFF_OUT_CAP_RB:
        begin
          if (state_q.unlocked)
          begin
            state_d.rdata[CKSEL_TRIM_W-1:0] = state_q.out_trim;
          end
        end
        CKSEL_OFF_CAP_ADJ:
        begin
          state_d.rdata[CKSEL_OUT_ADJ_LO +: CKSEL_ADJ_W] = state_q.out_adj;
          state_d.rdata[CKSEL_IN_ADJ_LO +: CKSEL_ADJ_W] = state_q.in_adj;
        end
        CKSEL_OFF_KEY:
        begin
          state_d.rdata[0] = state_q.unlocked;
        end
        CKSEL_OFF_SRC_SEL:
        begin
          // Forced fields show what actually drives the pins
          state_d.rdata[CKSEL_A_SRC_LO +: 2] = state_q.a_src;
          state_d.rdata[CKSEL_B_SRC_LO +: 2] = b_src_eff;
          state_d.rdata[CKSEL_C_SRC_BIT] = c_src_eff;
        end
        CKSEL_OFF_DIV_CTRL:
        begin
          state_d.rdata[CKSEL_B_DIV_BIT] = state_q.b_div;
          state_d.rdata[CKSEL_C_DIV_BIT] = state_q.c_div;
        end
        default:
        begin
          // Unmapped reads return zero
          state_d.rdata = 16'h0000;
        end
      endcase
    end

    // Output A steering; reserved code parks low
    case (state_q.a_src)
      CKSEL_A_PHASE_B: state_d.out_a = b_loop_div;
      CKSEL_A_PIN_TWO: state_d.out_a = state_q.sync2.general_pin_two;
      CKSEL_A_OSC: state_d.out_a = state_q.sync2.osc;
      default: state_d.out_a = 1'b0;
    endcase

    // Output B steering; reserved code parks low
    case (b_src_eff)
      CKSEL_B_PHASE_C: state_d.out_b = c_loop_div;
      CKSEL_B_PIN_THREE: state_d.out_b = state_q.sync2.general_pin_three;
      CKSEL_B_FLL: state_d.out_b = state_q.sync2.frequency_locked_loop;
      default: state_d.out_b = 1'b0;
    endcase

    // Output C steering
    if (c_src_eff == CKSEL_C_FLL)
    begin
      state_d.out_c = state_q.sync2.frequency_locked_loop;
    end
    else
    begin
      state_d.out_c = state_q.sync2.osc;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_q <= '0;
      state_q.init_cnt <= CKSEL_INIT_CYCLES;
      state_q.a_src <= CKSEL_A_SRC_RST;
      state_q.b_src <= CKSEL_B_FLL;
      state_q.c_src <= CKSEL_C_FLL;
      state_q.b_div <= CKSEL_B_DIV_RST;
      state_q.c_div <= CKSEL_C_DIV_RST;
      state_q.out_adj <= CKSEL_ADJ_RST;
      state_q.in_adj <= CKSEL_ADJ_RST;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = state_q.rdata;
  assign clk_out_a = state_q.out_a;
  assign clk_out_b = state_q.out_b;
  assign clk_out_c = state_q.out_c;
  assign crystal_in_cap_adjust = state_q.in_adj;
  assign crystal_out_cap_adjust = state_q.out_adj;

endmodule : cksel_top
